// ==== core/pds_regs.vh ====
`ifndef PDS_REGS_VH
`define PDS_REGS_VH
// register byte offsets
`define PDS_OFF_PMCSR 12'h000
`define PDS_OFF_CTRL 12'h004
`define PDS_OFF_STATUS 12'h008
// power_state_field position and codes
`define PDS_PSF_LSB 0
`define PDS_PSF_MSB 1
`define PDS_PSF_D0 2'h0
`define PDS_PSF_D3 2'h3
// wake_signal_enable position in pm_control_status_reg
`define PDS_WSE_BIT 8
// control register fields
`define PDS_CTRL_CFG_BIT 0
`define PDS_CTRL_WAKE_BIT 1
// state codes
`define PDS_ST_OFF 3'h0
`define PDS_ST_D0U 3'h1
`define PDS_ST_D0A 3'h2
`define PDS_ST_D3H 3'h3
`define PDS_ST_D3C 3'h4
// reset values
`define PDS_PMCSR_RST 32'h00000000
// d3 exit reset length in cycles
`define PDS_D3_EXIT_RESET_CYC 4'h8
`endif

// ==== core/pds_sync2.v ====
`timescale 1ns/1ps
`default_nettype none
module pds_sync2 (
  input wire clk,
  input wire nrst,
  input wire d,
  output reg q
);
  reg meta_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // pds_sync2
`default_nettype wire

// ==== core/pds_power_ctrl.v ====
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pds_regs.vh"
module pds_power_ctrl (
  input wire REF_CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire PCI_RESET_IN_N,
  input wire MAIN_POWER_GOOD,
  input wire AUX_POWER_DETECT,
  input wire WAKE_EVENT_IN,
  output reg PLL_CLK_EN,
  output reg ETH_ENABLE,
  output reg PCI_MEM_IO_EN,
  output reg PCI_CFG_EN,
  output reg PCI_RESET_SCOPE,
  output reg D3_EXIT_RESET,
  output reg PHY_RESET,
  output reg PHY_POWER_DOWN,
  output reg WAKE_EVENT_OUT_N,
  output reg PCI_IRQ_OUT_N
);
  //////////////////////////////////////////////////////////////////////
  wire prst_n_s;
  wire pgood_s;
  wire aux_s;
  wire wake_s;
  pds_sync2 u_s0 (.clk(REF_CLK), .nrst(NRST), .d(PCI_RESET_IN_N), .q(prst_n_s));
  pds_sync2 u_s1 (.clk(REF_CLK), .nrst(NRST), .d(MAIN_POWER_GOOD), .q(pgood_s));
  pds_sync2 u_s2 (.clk(REF_CLK), .nrst(NRST), .d(AUX_POWER_DETECT), .q(aux_s));
  pds_sync2 u_s3 (.clk(REF_CLK), .nrst(NRST), .d(WAKE_EVENT_IN), .q(wake_s));
  reg prst_d_r;
  reg pgood_d_r;
  reg aux_d_r;
  wire prst_fall = prst_d_r & ~prst_n_s;
  wire prst_rise = ~prst_d_r & prst_n_s;
  wire pgood_fall = pgood_d_r & ~pgood_s;
  wire aux_rise = ~aux_d_r & aux_s;
  //////////////////////////////////////////////////////////////////////
  // encoded state register
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] psf_r;
  reg wse_r;
  reg cfg_done_r;
  reg wake_irq_sel_r;
  reg phy_gpd_r;
  reg phy_was_reset_r;
  reg [3:0] d3_exit_reset_cnt_r;
  wire setup = PSEL & ~PENABLE;
  wire wr_pm = setup & PWRITE & (PADDR == `PDS_OFF_PMCSR);
  wire wr_ctrl = setup & PWRITE & (PADDR == `PDS_OFF_CTRL);
  wire [1:0] wr_psf = PWDATA[`PDS_PSF_MSB:`PDS_PSF_LSB];
  wire go_d3 = wr_pm & (wr_psf == `PDS_PSF_D3) & (psf_r == `PDS_PSF_D0);
  wire go_d0 = wr_pm & (wr_psf == `PDS_PSF_D0) & (psf_r == `PDS_PSF_D3);
  // d3cold and off ignore every access but a ctrl configure write in the cycle that leaves for d0
  wire bus_dead = (state_r == `PDS_ST_D3C) | (state_r == `PDS_ST_OFF);
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `PDS_ST_OFF:
      begin
        if (aux_rise & ~pgood_s)
          state_nxt = `PDS_ST_D3C;
        else if (pgood_s)
          state_nxt = `PDS_ST_D0U;
      end
      `PDS_ST_D0U:
      begin
        if (pgood_fall & ~aux_s)
          state_nxt = `PDS_ST_OFF;
        else if (pgood_fall)
          state_nxt = `PDS_ST_D3C;
        else if (!prst_n_s)
          state_nxt = `PDS_ST_D0U;
        else if (go_d3 & pgood_s)
          state_nxt = `PDS_ST_D3H;
        else if (cfg_done_r)
          state_nxt = `PDS_ST_D0A;
      end
      `PDS_ST_D0A:
      begin
        if (pgood_fall & ~aux_s)
          state_nxt = `PDS_ST_OFF;
        else if (pgood_fall)
          state_nxt = `PDS_ST_D3C;
        else if (prst_fall | ~prst_n_s)
          state_nxt = `PDS_ST_D0U;
        else if (go_d3)
          state_nxt = `PDS_ST_D3H;
      end
      `PDS_ST_D3H:
      begin
        if (pgood_fall & ~aux_s)
          state_nxt = `PDS_ST_OFF;
        else if (pgood_fall)
          state_nxt = `PDS_ST_D3C;
        else if (prst_rise)
          state_nxt = `PDS_ST_D0U;
        else if (go_d0 & prst_n_s)
          state_nxt = `PDS_ST_D0U;
      end
      `PDS_ST_D3C:
      begin
        if (~aux_s)
          state_nxt = `PDS_ST_OFF;
        else if (pgood_s)
          state_nxt = `PDS_ST_D0U;
      end
      default:
        state_nxt = `PDS_ST_OFF;
    endcase
  end
  //////////////////////////////////////////////////////////////////////
  wire enter_d3h = (state_nxt == `PDS_ST_D3H) & (state_r != `PDS_ST_D3H);
  wire enter_d3c = (state_nxt == `PDS_ST_D3C) & (state_r != `PDS_ST_D3C);
  wire exit_d3h_sw = (state_r == `PDS_ST_D3H) & (state_nxt == `PDS_ST_D0U) & ~prst_rise;
  wire exit_d3h = (state_r == `PDS_ST_D3H) & (state_nxt == `PDS_ST_D0U);
  wire to_off = (state_nxt == `PDS_ST_OFF);
  wire enter_off = to_off & (state_r != `PDS_ST_OFF);
  always @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      prst_d_r <= 1'b0;
      pgood_d_r <= 1'b0;
      aux_d_r <= 1'b0;
      state_r <= `PDS_ST_OFF;
      psf_r <= `PDS_PSF_D0;
      wse_r <= 1'b0;
      cfg_done_r <= 1'b0;
      wake_irq_sel_r <= 1'b0;
      phy_gpd_r <= 1'b0;
      phy_was_reset_r <= 1'b0;
      d3_exit_reset_cnt_r <= 4'h0;
    end
    else
    begin
      prst_d_r <= prst_n_s;
      pgood_d_r <= pgood_s;
      aux_d_r <= aux_s;
      state_r <= state_nxt;
      if (to_off)
      begin
        psf_r <= `PDS_PSF_D0;
        wse_r <= 1'b0;
        cfg_done_r <= 1'b0;
        wake_irq_sel_r <= 1'b0;
        phy_gpd_r <= 1'b0;
        phy_was_reset_r <= 1'b0;
      end
      // entry to d3cold from any state; coming from off also clears wse (por behaviour)
      else if (enter_d3c)
      begin
        if (state_r == `PDS_ST_OFF)
          wse_r <= 1'b0;
        psf_r <= `PDS_PSF_D3;
        cfg_done_r <= 1'b0;
        phy_gpd_r <= 1'b1;
        phy_was_reset_r <= 1'b1;
      end
      else
      begin
        if (wr_pm & ~bus_dead)
        begin
          psf_r <= wr_psf;
          wse_r <= PWDATA[`PDS_WSE_BIT];
        end
        if (wr_ctrl & ~bus_dead)
          wake_irq_sel_r <= PWDATA[`PDS_CTRL_WAKE_BIT];
        // configure marks only in D0 states
        if (state_nxt != `PDS_ST_D0U && state_nxt != `PDS_ST_D0A)
          cfg_done_r <= 1'b0;
        else if (wr_ctrl & PWDATA[`PDS_CTRL_CFG_BIT] & prst_n_s)
          cfg_done_r <= 1'b1;
        else if (!prst_n_s)
          cfg_done_r <= 1'b0;
        if (enter_d3h)
        begin
          phy_gpd_r <= ~wse_r;
          phy_was_reset_r <= ~wse_r;
        end
        else if (exit_d3h)
          phy_gpd_r <= 1'b0;
        else if (state_r == `PDS_ST_D3C && state_nxt == `PDS_ST_D0U)
          phy_gpd_r <= 1'b0;
        // every way back from d3hot or d3cold into uninit d0 reads 00b
        if (state_nxt == `PDS_ST_D0U && (state_r == `PDS_ST_D3C || state_r == `PDS_ST_D3H))
          psf_r <= `PDS_PSF_D0;
      end
      if (exit_d3h_sw)
        d3_exit_reset_cnt_r <= `PDS_D3_EXIT_RESET_CYC;
      else if (d3_exit_reset_cnt_r != 4'h0)
        d3_exit_reset_cnt_r <= d3_exit_reset_cnt_r - 4'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire sel_ok = (PADDR == `PDS_OFF_PMCSR) | (PADDR == `PDS_OFF_CTRL) |
    (PADDR == `PDS_OFF_STATUS);
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (PADDR)
      `PDS_OFF_PMCSR:
      begin
        rd_nxt[`PDS_PSF_MSB:`PDS_PSF_LSB] = psf_r;
        rd_nxt[`PDS_WSE_BIT] = wse_r;
      end
      `PDS_OFF_CTRL:
      begin
        rd_nxt[`PDS_CTRL_CFG_BIT] = cfg_done_r;
        rd_nxt[`PDS_CTRL_WAKE_BIT] = wake_irq_sel_r;
      end
      `PDS_OFF_STATUS:
        rd_nxt = {24'h000000, phy_gpd_r, phy_was_reset_r, 3'h0, state_r};
      default:
        rd_nxt = 32'h00000000;
    endcase
  end
  always @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup & (~sel_ok | bus_dead);
      if (setup & ~PWRITE)
        PRDATA <= bus_dead ? 32'h00000000 : rd_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // enables registered from next state so they track state_r; wake outputs decode state_r
  wire d0_nxt = (state_nxt == `PDS_ST_D0U) | (state_nxt == `PDS_ST_D0A);
  always @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      PLL_CLK_EN <= 1'b0;
      ETH_ENABLE <= 1'b0;
      PCI_MEM_IO_EN <= 1'b0;
      PCI_CFG_EN <= 1'b0;
      PCI_RESET_SCOPE <= 1'b1;
      D3_EXIT_RESET <= 1'b0;
      PHY_RESET <= 1'b1;
      PHY_POWER_DOWN <= 1'b0;
      WAKE_EVENT_OUT_N <= 1'b1;
      PCI_IRQ_OUT_N <= 1'b1;
    end
    else
    begin
      PLL_CLK_EN <= d0_nxt;
      ETH_ENABLE <= (state_nxt == `PDS_ST_D0A);
      PCI_MEM_IO_EN <= d0_nxt;
      PCI_CFG_EN <= d0_nxt | (state_nxt == `PDS_ST_D3H);
      // reset scope follows pin in d0
      PCI_RESET_SCOPE <= (d0_nxt & ~prst_n_s) | to_off;
      D3_EXIT_RESET <= exit_d3h_sw | (d3_exit_reset_cnt_r > 4'h1);
      // phy reset pulses on entry to off and on entries that power it down
      PHY_RESET <= enter_off | (enter_d3h & ~wse_r) | enter_d3c;
      PHY_POWER_DOWN <= enter_d3c | (enter_d3h ? ~wse_r : phy_gpd_r & ~exit_d3h);
      // active d0 wake to irq or wake pin
      WAKE_EVENT_OUT_N <= ~(wake_s & wse_r &
        ((state_r == `PDS_ST_D0A & ~wake_irq_sel_r) |
        (state_r == `PDS_ST_D3H) | (state_r == `PDS_ST_D3C)));
      PCI_IRQ_OUT_N <= ~(wake_s & wse_r & wake_irq_sel_r & (state_r == `PDS_ST_D0A));
    end
  end
endmodule // pds_power_ctrl
`default_nettype wire

// ==== verification/pds_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pds_chk (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PCI_RESET_IN_N,
  input wire logic MAIN_POWER_GOOD,
  input wire logic AUX_POWER_DETECT,
  input wire logic PLL_CLK_EN,
  input wire logic ETH_ENABLE,
  input wire logic PCI_MEM_IO_EN,
  input wire logic PCI_CFG_EN,
  input wire logic PHY_RESET,
  input wire logic PHY_POWER_DOWN,
  input wire logic WAKE_EVENT_OUT_N
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////
  a_answer_next:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no answer after setup");
  a_ready_pulse:
    assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_eth_in_d0:
    assert property (ETH_ENABLE |-> PLL_CLK_EN && PCI_MEM_IO_EN) else $error("eth outside d0");
  a_memio_clocks:
    assert property (PCI_MEM_IO_EN |-> PLL_CLK_EN && PCI_CFG_EN) else $error("memio without clocks");
  a_d3_quiet:
    assert property (PCI_CFG_EN && !PLL_CLK_EN |-> !PCI_MEM_IO_EN && !ETH_ENABLE)
      else $error("d3hot grants access");
  a_field_read:
    assert property (PREADY && !PWRITE && PADDR == 12'h000 && PCI_CFG_EN
      |-> PRDATA[1:0] == (PCI_MEM_IO_EN ? 2'h0 : 2'h3)) else $error("bad state field");
  a_refused_cold:
    assert property (PREADY && !PCI_CFG_EN |-> PSLVERR) else $error("access taken unpowered");
  a_off_quiet:
    assert property ((!AUX_POWER_DETECT && !MAIN_POWER_GOOD) [*8]
      |-> !PCI_CFG_EN && WAKE_EVENT_OUT_N) else $error("alive without power");
  a_cold_phy_down:
    assert property ((AUX_POWER_DETECT && !MAIN_POWER_GOOD) [*8]
      |-> PHY_POWER_DOWN && !PLL_CLK_EN) else $error("d3cold phy or pll on");
  a_pcirst_hold:
    assert property ((!PCI_RESET_IN_N) [*8] |-> !ETH_ENABLE) else $error("active under pci reset");
  a_phy_pulse:
    assert property ($rose(PHY_RESET) |=> !PHY_RESET) else $error("phy reset not a pulse");
endmodule // pds_chk
bind pds_power_ctrl pds_chk pds_chk_inst (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PCI_RESET_IN_N(PCI_RESET_IN_N), .MAIN_POWER_GOOD(MAIN_POWER_GOOD),
  .AUX_POWER_DETECT(AUX_POWER_DETECT), .PLL_CLK_EN(PLL_CLK_EN), .ETH_ENABLE(ETH_ENABLE),
  .PCI_MEM_IO_EN(PCI_MEM_IO_EN), .PCI_CFG_EN(PCI_CFG_EN), .PHY_RESET(PHY_RESET),
  .PHY_POWER_DOWN(PHY_POWER_DOWN), .WAKE_EVENT_OUT_N(WAKE_EVENT_OUT_N));
`default_nettype wire

// ==== verification/pds_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pds_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic rst_n,
  output logic pg,
  output logic aux,
  output logic wake
);
  logic [31:0] rd;
  logic er;
  initial {psel, penable, pwrite, paddr, pwdata, rst_n, pg, aux, wake} = '0;
  ////////////////////////////////////////////////////////////
  // host read or write of any apb register
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed, bench timeout ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pwr(input logic [2:0] v);
    @(posedge clk);
    {rst_n, aux, pg} <= v;
  endtask
  task wk(input logic v);
    @(posedge clk);
    wake <= v;
  endtask
endmodule // pds_host
`default_nettype wire

// ==== verification/pds_power_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pds_power_ctrl_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rst_n, pg, aux, wake, rf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pll, eth, mem, cfg, scope, d3r, phyr, phypd, wo_n, irq_n;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // kind F = power {rst_n,aux,pg}, else write address; then data, state
  logic [19:0] rows [24] = '{20'hF0051, 20'h00033, 20'hF0013, 20'hF0051,
    20'h00033, 20'h00001, 20'h40012, 20'h01033, 20'h01001, 20'h40012,
    20'hF0011, 20'hF0051, 20'hF0071, 20'hF0064, 20'hF0024, 20'hF0071,
    20'h40012, 20'hF0064, 20'hF0040, 20'hF0024, 20'hF0031, 20'hF0051,
    20'hF0040, 20'hF0051};
  pds_power_ctrl pds_power_ctrl_inst (.REF_CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PCI_RESET_IN_N(rst_n), .MAIN_POWER_GOOD(pg),
    .AUX_POWER_DETECT(aux), .WAKE_EVENT_IN(wake), .PLL_CLK_EN(pll), .ETH_ENABLE(eth),
    .PCI_MEM_IO_EN(mem), .PCI_CFG_EN(cfg), .PCI_RESET_SCOPE(scope), .D3_EXIT_RESET(d3r),
    .PHY_RESET(phyr), .PHY_POWER_DOWN(phypd), .WAKE_EVENT_OUT_N(wo_n), .PCI_IRQ_OUT_N(irq_n));
  pds_host pds_host_inst (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .rst_n(rst_n), .pg(pg), .aux(aux), .wake(wake));
  ////////////////////////////////////////////////////////////
  // continuous reference clock
  initial forever #25 clk = ~clk;
  // one bit wider than a word so the error flag is compared too
  task chk(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // 10 cycles covers the 2-ff sync plus edge detect
  task step(input logic [3:0] st);
    repeat (10) @(posedge clk);
    rf = (st == 4'h0 || st == 4'h4);
    pds_host_inst.apb(1'b0, 12'h008, 32'h00000000);
    chk({pds_host_inst.er, pds_host_inst.rd[2:0]}, {rf, rf ? 3'h0 : st[2:0]});
    pds_host_inst.apb(1'b0, 12'h000, 32'h00000000);
    chk({pds_host_inst.er, pds_host_inst.rd[1:0]}, {rf, st == 4'h3 ? 2'h3 : 2'h0});
    chk({pll, eth, mem, cfg},
      st == 4'h1 ? 4'hB : st == 4'h2 ? 4'hF : st == 4'h3 ? 4'h1 : 4'h0);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][19:16] == 4'hF)
        pds_host_inst.pwr(rows[i][6:4]);
      else
        pds_host_inst.apb(1'b1, {8'h00, rows[i][19:16]}, {20'h00000, rows[i][15:4]});
      step(rows[i][3:0]);
    end
    pds_host_inst.apb(1'b0, 12'h00C, 32'h00000000);
    chk({pds_host_inst.er, pds_host_inst.rd}, {1'b1, 32'h00000000});
    // wake enabled, then configure with wake routed to the interrupt
    pds_host_inst.apb(1'b1, 12'h000, 32'h00000100);
    pds_host_inst.apb(1'b1, 12'h004, 32'h00000003);
    step(4'h2);
    pds_host_inst.wk(1'b1);
    repeat (8) @(posedge clk);
    chk({irq_n, wo_n}, 2'h1);
    pds_host_inst.wk(1'b0);
    pds_host_inst.apb(1'b1, 12'h000, 32'h00000103);
    step(4'h3);
    chk(phypd, 1'b0);
    pds_host_inst.wk(1'b1);
    repeat (8) @(posedge clk);
    chk(wo_n, 1'b0);
    pds_host_inst.wk(1'b0);
    pds_host_inst.apb(1'b1, 12'h000, 32'h00000100);
    chk(d3r, 1'b1);
    repeat (10) @(posedge clk);
    chk(d3r, 1'b0);
    pds_host_inst.pwr(3'h1);
    repeat (8) @(posedge clk);
    chk({scope, eth}, 2'h2);
    pds_host_inst.pwr(3'h5);
    pds_host_inst.apb(1'b1, 12'h000, 32'h00000000);
    pds_host_inst.apb(1'b1, 12'h000, 32'h00000003);
    step(4'h3);
    chk(phypd, 1'b1);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({pll, cfg, scope, phyr, wo_n}, 5'h07);
    nrst <= 1'b1;
    step(4'h1);
    end_sim;
  end
endmodule // pds_power_ctrl_test
`default_nettype wire
